// ===== sas_pkg.sv
// Operation
// - start conversions by a mode register write or by a trigger pin edge
// - scan mode converts channels zero up to the chosen one, in order, repeatedly
// - select mode converts the one chosen channel again and again
// - each finished conversion lands in a result register and pulses conversion-end
// - conversion-end pulse is usable by the macro service transfer hardware
// - ten-bit approximation register decides MSB first; final value copied to result
// - the selected input is sampled once and held for the whole conversion
// - trigger pin edge detector gives external interrupt and converter trigger
// - mode bits 2:0 choose the channel within the active bank
// - mode bit 3 clear selects the low bank of eight channels
// - mode bit 3 set routes the high bank of eight channels
// - mode bits 6:5 give stop, scan, select one-buffer, select four-buffer
// - stop mode halts conversion, keeps results, no conversion-end interrupt, comparator unpowered
// - conversions repeat until software writes stop mode
// - with trigger enabled, every valid trigger edge restarts the sequence
// - with trigger disabled, the trigger pin has no effect on conversion
// - any mode register write aborts and restarts under the new settings
// - mode bit 4 clear gives 208 clocks, set gives 169 clocks
// - mode register resets to zero, byte and single-bit writable and readable
// - low-power state halts conversion but keeps comparator powered
package sas_pkg;

  // ==========================================================
  // register map
  localparam logic [15:0] MODE_ADDR  = 16'hff6e;
  localparam logic [15:0] RSLT_BASE  = 16'hff70;
  localparam logic [7:0]  MODE_RST   = 8'h00;

  // ==========================================================
  // mode register fields
  localparam int BIT_BANK   = 3;
  localparam int BIT_CTIME  = 4;
  localparam int BIT_OPLO   = 5;
  localparam int BIT_OPHI   = 6;
  localparam int BIT_TRIGEN = 7;

  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_SCAN = 2'h1;
  localparam logic [1:0] MODE_SEL1 = 2'h2;
  localparam logic [1:0] MODE_SEL4 = 2'h3;

  // ==========================================================
  // conversion timing, in clocks
  localparam logic [7:0] CONV_LEN_LONG  = 8'd208;
  localparam logic [7:0] CONV_LEN_SHORT = 8'd169;
  localparam logic [7:0] SAMP_LEN_LONG  = 8'd48;
  localparam logic [7:0] SAMP_LEN_SHORT = 8'd39;
  localparam logic [4:0] STEP_LEN_LONG  = 5'd16;
  localparam logic [4:0] STEP_LEN_SHORT = 5'd13;

  localparam logic [9:0] APPROX_MSB     = 10'h200;
  localparam logic [3:0] APPROX_TOP_BIT = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_CONV = 3'b100
  } sas_state_t;

endpackage : sas_pkg

// ===== sas_result_mem.sv
`timescale 1ns/1ns
module sas_result_mem (
  input  wire logic       clk,
  input  wire logic       wrEn,
  input  wire logic [2:0] wrIdx,
  input  wire logic [9:0] wrData,
  input  wire logic [2:0] rdIdx,
  output logic      [9:0] rdData
);
  // contents are undefined after reset, so the array carries no reset
  logic [9:0] mem [0:7];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
    rdData <= mem[rdIdx];
  end
endmodule : sas_result_mem

// ===== sas_sar_adc_sequencer.sv
`timescale 1ns/1ns
module sas_sar_adc_sequencer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] busAddr,
  input  wire logic [7:0]  busWrData,
  input  wire logic [7:0]  busWrMask,
  input  wire logic        busWr,
  input  wire logic        busRd,
  output logic      [15:0] busRdData,
  output logic             busRdValid,
  input  wire logic        extTriggerPin,
  input  wire logic [1:0]  extIrqEdgeSel,
  output logic             extIrq,
  input  wire logic        lowPowerReq,
  input  wire logic        compOut,
  output logic      [9:0]  approxCode,
  output logic      [3:0]  analogSel,
  output logic             sampleHold,
  output logic             compPwr,
  output logic             convEndIrq
);

  // ==========================================================
  // declarations
  sas_pkg::sas_state_t state_r;
  logic [7:0]  modeReg_r;
  logic [1:0]  trigSync_r;
  logic        trigPrev_r;
  logic [1:0]  compSync_r;
  logic [7:0]  cnt_r;
  logic [4:0]  stepCnt_r;
  logic [3:0]  bitIdx_r;
  logic [9:0]  approx_r;
  logic [2:0]  scanPos_r;
  logic [1:0]  bufIdx_r;
  logic [3:0]  analogSel_r;
  logic        sampleHold_r;
  logic        compPwr_r;
  logic        convEndIrq_r;
  logic        extIrq_r;
  logic        rdPend_r;
  logic        rdMode_r;
  logic        rdRslt_r;
  logic        rdHi_r;
  logic [7:0]  rdModeVal_r;
  logic [15:0] busRdData_r;
  logic        busRdValid_r;
  logic [9:0]  memRdData;

  logic        modeWr;
  logic [7:0]  modeNew;
  logic [7:0]  cfg;
  logic [1:0]  opMode;
  logic [1:0]  cfgMode;
  logic        trigEdge;
  logic        restart;
  logic        running;
  logic        done;
  logic [7:0]  lastCnt;
  logic [7:0]  sampLen;
  logic [4:0]  stepLen;
  logic [2:0]  scanNext;
  logic [2:0]  rsltIdx;
  logic [9:0]  rsltData;
  logic [8:0]  cntAhead;

  // ==========================================================
  // input synchronisers and trigger edge detector
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trigSync_r <= 2'h0;
      trigPrev_r <= 1'b0;
      compSync_r <= 2'h0;
    end else begin
      trigSync_r <= {trigSync_r[0], extTriggerPin};
      trigPrev_r <= trigSync_r[1];
      compSync_r <= {compSync_r[0], compOut};
    end
  end

  // edge select: bit 0 rising, bit 1 falling, both set for either edge
  assign trigEdge = (extIrqEdgeSel[0] & trigSync_r[1] & ~trigPrev_r)
                  | (extIrqEdgeSel[1] & ~trigSync_r[1] & trigPrev_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      extIrq_r <= 1'b0;
    end else begin
      extIrq_r <= trigEdge;
    end
  end

  // ==========================================================
  // mode register
  assign modeWr  = busWr && (busAddr == sas_pkg::MODE_ADDR);
  assign modeNew = (modeReg_r & ~busWrMask) | (busWrData & busWrMask);
  assign cfg     = modeWr ? modeNew : modeReg_r;
  assign opMode  = modeReg_r[sas_pkg::BIT_OPHI:sas_pkg::BIT_OPLO];
  assign cfgMode = cfg[sas_pkg::BIT_OPHI:sas_pkg::BIT_OPLO];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg_r <= sas_pkg::MODE_RST;
    end else if (modeWr) begin
      modeReg_r <= modeNew;
    end
  end

  // a trigger only counts when enabled and a mode is active
  assign restart = modeWr
                 | (modeReg_r[sas_pkg::BIT_TRIGEN] && (opMode != sas_pkg::MODE_STOP)
                    && trigEdge);

  // ==========================================================
  // timing selection
  assign lastCnt = modeReg_r[sas_pkg::BIT_CTIME] ? (sas_pkg::CONV_LEN_SHORT - 8'd1)
                                                 : (sas_pkg::CONV_LEN_LONG - 8'd1);
  assign sampLen = modeReg_r[sas_pkg::BIT_CTIME] ? sas_pkg::SAMP_LEN_SHORT
                                                 : sas_pkg::SAMP_LEN_LONG;
  assign stepLen = modeReg_r[sas_pkg::BIT_CTIME] ? sas_pkg::STEP_LEN_SHORT
                                                 : sas_pkg::STEP_LEN_LONG;

  // low power freezes the sequencer in place rather than abandoning it
  assign running = (state_r == sas_pkg::ST_CONV) && !lowPowerReq;
  assign done    = running && !restart && (cnt_r == lastCnt);

  // ==========================================================
  // sequencer state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= sas_pkg::ST_IDLE;
    end else if (restart) begin
      if (cfgMode == sas_pkg::MODE_STOP) begin
        state_r <= sas_pkg::ST_IDLE;
      end else if (modeWr && cfg[sas_pkg::BIT_TRIGEN]) begin
        state_r <= sas_pkg::ST_WAIT;
      end else begin
        state_r <= sas_pkg::ST_CONV;
      end
    end else begin
      case (state_r)
        sas_pkg::ST_IDLE: state_r <= sas_pkg::ST_IDLE;
        sas_pkg::ST_WAIT: state_r <= sas_pkg::ST_WAIT;
        sas_pkg::ST_CONV: state_r <= sas_pkg::ST_CONV;
        default:          state_r <= sas_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // approximation datapath
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r     <= 8'h00;
      stepCnt_r <= 5'h00;
      bitIdx_r  <= sas_pkg::APPROX_TOP_BIT;
      approx_r  <= 10'h000;
    end else if (restart || done) begin
      cnt_r     <= 8'h00;
      stepCnt_r <= 5'h00;
      bitIdx_r  <= sas_pkg::APPROX_TOP_BIT;
      approx_r  <= sas_pkg::APPROX_MSB;
    end else if (running) begin
      cnt_r <= cnt_r + 8'd1;
      if (cnt_r >= sampLen) begin
        if (stepCnt_r == stepLen - 5'd1) begin
          stepCnt_r       <= 5'h00;
          approx_r[bitIdx_r] <= compSync_r[1];
          if (bitIdx_r != 4'h0) begin
            approx_r[bitIdx_r - 4'd1] <= 1'b1;
            bitIdx_r               <= bitIdx_r - 4'd1;
          end
        end else begin
          stepCnt_r <= stepCnt_r + 5'd1;
        end
      end
    end
  end

  // bit 0 is decided on the final clock and goes straight to the result
  assign rsltData = {approx_r[9:1], compSync_r[1]};

  // ==========================================================
  // channel sequencing and result placement
  assign scanNext = (scanPos_r == modeReg_r[2:0]) ? 3'h0 : scanPos_r + 3'd1;

  always_comb begin
    case (opMode)
      sas_pkg::MODE_SCAN: rsltIdx = scanPos_r;
      sas_pkg::MODE_SEL1: rsltIdx = modeReg_r[2:0];
      sas_pkg::MODE_SEL4: rsltIdx = {1'b0, bufIdx_r};
      default:            rsltIdx = 3'h0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scanPos_r   <= 3'h0;
      bufIdx_r    <= 2'h0;
      analogSel_r <= 4'h0;
    end else if (restart) begin
      scanPos_r   <= 3'h0;
      bufIdx_r    <= 2'h0;
      analogSel_r <= {cfg[sas_pkg::BIT_BANK],
                      (cfgMode == sas_pkg::MODE_SCAN) ? 3'h0 : cfg[2:0]};
    end else if (done) begin
      scanPos_r   <= scanNext;
      bufIdx_r    <= bufIdx_r + 2'd1;
      analogSel_r <= {modeReg_r[sas_pkg::BIT_BANK],
                      (opMode == sas_pkg::MODE_SCAN) ? scanNext : modeReg_r[2:0]};
    end
  end

  sas_result_mem u_mem (
    .clk    (clk),
    .wrEn   (done),
    .wrIdx  (rsltIdx),
    .wrData (rsltData),
    .rdIdx  (busAddr[3:1]),
    .rdData (memRdData)
  );

  // ==========================================================
  // analog control outputs and completion pulse
  assign cntAhead = lowPowerReq ? {1'b0, cnt_r} : ({1'b0, cnt_r} + 9'd1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sampleHold_r <= 1'b0;
      compPwr_r    <= 1'b0;
      convEndIrq_r <= 1'b0;
    end else begin
      if (restart) begin
        sampleHold_r <= (cfgMode != sas_pkg::MODE_STOP) && !(modeWr && cfg[sas_pkg::BIT_TRIGEN]);
      end else if (done) begin
        sampleHold_r <= 1'b1;
      end else begin
        sampleHold_r <= (state_r == sas_pkg::ST_CONV) && (cntAhead < {1'b0, sampLen});
      end
      compPwr_r    <= (cfgMode != sas_pkg::MODE_STOP);
      convEndIrq_r <= done;
    end
  end

  // ==========================================================
  // register read path, two cycles from request to data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdPend_r     <= 1'b0;
      rdMode_r     <= 1'b0;
      rdRslt_r     <= 1'b0;
      rdHi_r       <= 1'b0;
      rdModeVal_r  <= 8'h00;
      busRdData_r  <= 16'h0000;
      busRdValid_r <= 1'b0;
    end else begin
      rdPend_r   <= busRd;
      rdMode_r    <= busRd && (busAddr == sas_pkg::MODE_ADDR);
      rdRslt_r    <= busRd && (busAddr[15:4] == sas_pkg::RSLT_BASE[15:4]);
      rdHi_r      <= busAddr[0];
      rdModeVal_r <= modeReg_r;
      busRdValid_r <= rdPend_r;
      if (rdMode_r) begin
        busRdData_r <= {8'h00, rdModeVal_r};
      end else if (rdRslt_r && rdHi_r) begin
        busRdData_r <= {8'h00, memRdData[9:2]};
      end else if (rdRslt_r) begin
        busRdData_r <= {6'h00, memRdData};
      end else begin
        busRdData_r <= 16'h0000;
      end
    end
  end

  assign busRdData  = busRdData_r;
  assign busRdValid = busRdValid_r;
  assign extIrq     = extIrq_r;
  assign approxCode = approx_r;
  assign analogSel  = analogSel_r;
  assign sampleHold = sampleHold_r;
  assign compPwr    = compPwr_r;
  assign convEndIrq = convEndIrq_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_stop_no_irq;
    (opMode == sas_pkg::MODE_STOP) |=> !convEndIrq;
  endproperty
  a_stop_no_irq: assert property (p_stop_no_irq) else $error("irq in stop mode");

  property p_stop_unpowered;
    (modeWr && cfgMode == sas_pkg::MODE_STOP) |=> !compPwr ##1 !compPwr;
  endproperty
  a_stop_unpowered: assert property (p_stop_unpowered) else $error("comparator on");

  property p_lowpower_hold;
    (lowPowerReq && opMode != sas_pkg::MODE_STOP && !modeWr) |=> compPwr && !convEndIrq;
  endproperty
  a_lowpower_hold: assert property (p_lowpower_hold) else $error("low power wrong");

  property p_write_restart;
    (modeWr && cfgMode != sas_pkg::MODE_STOP) |=> (cnt_r == 8'h00) && !convEndIrq;
  endproperty
  a_write_restart: assert property (p_write_restart) else $error("no restart");

  property p_done_irq;
    done |=> convEndIrq ##1 !convEndIrq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("irq not pulsed");

  property p_trig_irq;
    trigEdge |=> extIrq;
  endproperty
  a_trig_irq: assert property (p_trig_irq) else $error("ext irq missing");

  property p_trig_restart;
    (trigEdge && modeReg_r[sas_pkg::BIT_TRIGEN] && opMode != sas_pkg::MODE_STOP && !modeWr)
      |=> (state_r == sas_pkg::ST_CONV) && (cnt_r == 8'h00)
          && (approx_r == sas_pkg::APPROX_MSB);
  endproperty
  a_trig_restart: assert property (p_trig_restart) else $error("trigger ignored");

  property p_wait_needs_trg;
    (state_r == sas_pkg::ST_WAIT) |-> modeReg_r[sas_pkg::BIT_TRIGEN];
  endproperty
  a_wait_needs_trg: assert property (p_wait_needs_trg) else $error("wait without trg");

  property p_mux_stable;
    (state_r == sas_pkg::ST_CONV && cnt_r != 8'h00) |-> $stable(analogSel);
  endproperty
  a_mux_stable: assert property (p_mux_stable) else $error("input moved");

  property p_scan_wrap;
    (done && opMode == sas_pkg::MODE_SCAN && scanPos_r == modeReg_r[2:0]) |=> scanPos_r == 3'h0;
  endproperty
  a_scan_wrap: assert property (p_scan_wrap) else $error("scan no wrap");

  property p_done_len;
    done |-> cnt_r == (modeReg_r[sas_pkg::BIT_CTIME] ? 8'd168 : 8'd207);
  endproperty
  a_done_len: assert property (p_done_len) else $error("wrong length");

  c_scan_done: cover property (done && opMode == sas_pkg::MODE_SCAN && scanPos_r != 3'h0);
  c_sel4_done: cover property (done && opMode == sas_pkg::MODE_SEL4 && bufIdx_r == 2'h3);
  c_trig_start: cover property ((state_r == sas_pkg::ST_WAIT) ##1 (state_r == sas_pkg::ST_CONV));
  c_fast_done: cover property (done && modeReg_r[sas_pkg::BIT_CTIME]);

endmodule : sas_sar_adc_sequencer

// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
  // ==========================================================
  // stimulus and observation
  logic        clk;
  logic        rst_n;
  logic [15:0] busAddr;
  logic [7:0]  busWrData;
  logic [7:0]  busWrMask;
  logic        busWr;
  logic        busRd;
  logic [15:0] busRdData;
  logic        busRdValid;
  logic        extTriggerPin;
  logic [1:0]  extIrqEdgeSel;
  logic        extIrq;
  logic        lowPowerReq;
  logic        compOut;
  logic [9:0]  approxCode;
  logic [3:0]  analogSel;
  logic        sampleHold;
  logic        compPwr;
  logic        convEndIrq;
  logic        shD;
  logic [9:0]  r;
  logic [3:0]  selQ[$];
  int          errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          tWr = 0;
  int          nIrq = 0;
  int          nExt = 0;
  int          n;
  int          m;
  int          i;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  sas_sar_adc_sequencer i_dut (
    .clk           (clk),
    .rst_n         (rst_n),
    .busAddr       (busAddr),
    .busWrData     (busWrData),
    .busWrMask     (busWrMask),
    .busWr         (busWr),
    .busRd         (busRd),
    .busRdData     (busRdData),
    .busRdValid    (busRdValid),
    .extTriggerPin (extTriggerPin),
    .extIrqEdgeSel (extIrqEdgeSel),
    .extIrq        (extIrq),
    .lowPowerReq   (lowPowerReq),
    .compOut       (compOut),
    .approxCode    (approxCode),
    .analogSel     (analogSel),
    .sampleHold    (sampleHold),
    .compPwr       (compPwr),
    .convEndIrq    (convEndIrq)
  );

  // ==========================================================
  // analog stand-in: each of the 16 inputs holds a fixed level
  function automatic logic [9:0] tgt(input logic [3:0] s);
    return 10'h0a5 + {6'h00, s} * 10'h03b;
  endfunction : tgt

  // the comparator keeps the trial bit while the input is at or above the tap
  always @(negedge clk) compOut <= (tgt(analogSel) >= approxCode);

  always @(posedge clk) begin
    cyc <= cyc + 1;
    shD <= sampleHold;
    if (convEndIrq === 1'b1) nIrq <= nIrq + 1;
    if (extIrq === 1'b1) nExt <= nExt + 1;
    if (sampleHold === 1'b1 && shD !== 1'b1) selQ.push_back(analogSel);
  end

  // ==========================================================
  // bus and check tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] k);
    @(negedge clk);
    busAddr = a;
    busWrData = d;
    busWrMask = k;
    busWr = 1'b1;
    @(negedge clk);
    busWr = 1'b0;
    // only a mode write restarts the sequence, so only it resets the reference
    if (a == 16'hff6e) tWr = cyc;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    int k;
    @(negedge clk);
    busAddr = a;
    busRd = 1'b1;
    @(negedge clk);
    busRd = 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (busRdValid !== 1'b1 && k < 4);
    chk(busRdData, exp);
  endtask : rd

  // elapsed edges since the last mode write or trigger land in n
  task automatic wait_irq(input int lim);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (convEndIrq !== 1'b1 && k < lim);
    n = cyc - tWr;
  endtask : wait_irq

  task automatic end_of_test;
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // watchdog: the sequence needs well under 6000 cycles
  initial begin
    #3000000;
    errors++;
    end_of_test();
  end

  // ==========================================================
  // test sequence
  initial begin
    rst_n = 1'b0;
    busAddr = 16'h0000;
    busWrData = 8'h00;
    busWrMask = 8'h00;
    busWr = 1'b0;
    busRd = 1'b0;
    extTriggerPin = 1'b0;
    extIrqEdgeSel = 2'h1;
    lowPowerReq = 1'b0;
    compOut = 1'b0;
    repeat (16) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk({15'h0000, compPwr}, 16'h0000);
    rd(16'hff6e, 16'h0000);
    wr(16'hff6e, 8'hff, 8'h10);
    rd(16'hff6e, 16'h0010);
    rd(16'hff00, 16'h0000);
    selQ.delete();
    wr(16'hff6e, 8'h55, 8'hff);
    wait_irq(400);
    chk(n[15:0], 16'd169);
    chk({12'h000, selQ[0]}, 16'h0005);
    r = tgt(4'h5);
    rd(16'hff7a, {6'h00, r});
    rd(16'hff7b, {8'h00, r[9:2]});
    wr(16'hff7a, 8'h00, 8'hff);
    rd(16'hff7a, {6'h00, r});
    wait_irq(400);
    chk(n[15:0], 16'd338);
    repeat (60) @(negedge clk);
    wr(16'hff6e, 8'h55, 8'hff);
    wait_irq(400);
    chk(n[15:0], 16'd169);
    // stop in mid conversion: no further completions, comparator unpowered
    repeat (30) @(negedge clk);
    wr(16'hff6e, 8'h00, 8'hff);
    m = nIrq;
    repeat (400) @(negedge clk);
    chk(16'(nIrq - m), 16'h0000);
    chk({15'h0000, compPwr}, 16'h0000);
    // scan over three channels of the high bank, long length
    selQ.delete();
    wr(16'hff6e, 8'h2a, 8'hff);
    wait_irq(400);
    chk(n[15:0], 16'd208);
    repeat (3) wait_irq(400);
    chk(n[15:0], 16'd832);
    for (i = 0; i < 4; i++) chk({12'h000, selQ[i]}, {12'h000, 4'h8 + 4'(i % 3)});
    for (i = 0; i < 3; i++) rd(16'hff70 + 16'(2 * i), {6'h00, tgt(4'(8 + i))});
    // select with four buffers rotates result slots
    wr(16'hff6e, 8'h00, 8'hff);
    selQ.delete();
    wr(16'hff6e, 8'h71, 8'hff);
    repeat (2) wait_irq(400);
    chk({12'h000, selQ[1]}, 16'h0001);
    for (i = 0; i < 2; i++) rd(16'hff70 + 16'(2 * i), {6'h00, tgt(4'h1)});
    // low-power request freezes the count but keeps the comparator up
    wr(16'hff6e, 8'h50, 8'hff);
    repeat (20) @(negedge clk);
    lowPowerReq = 1'b1;
    repeat (100) @(negedge clk);
    chk({15'h0000, compPwr}, 16'h0001);
    lowPowerReq = 1'b0;
    wait_irq(400);
    chk(n[15:0], 16'd269);
    // trigger disabled: a pin edge does not disturb the sequence
    wr(16'hff6e, 8'h53, 8'hff);
    repeat (40) @(negedge clk);
    extTriggerPin = 1'b1;
    repeat (10) @(negedge clk);
    extTriggerPin = 1'b0;
    wait_irq(400);
    chk(n[15:0], 16'd169);
    // trigger enabled: wait for the pin, then each rising edge restarts
    wr(16'hff6e, 8'hd3, 8'hff);
    m = nIrq;
    repeat (300) @(negedge clk);
    chk(16'(nIrq - m), 16'h0000);
    extTriggerPin = 1'b1;
    tWr = cyc;
    wait_irq(400);
    m = n;
    chk({15'h0000, 1'(m >= 170 && m <= 176)}, 16'h0001);
    repeat (50) @(negedge clk);
    extTriggerPin = 1'b0;
    repeat (5) @(negedge clk);
    extTriggerPin = 1'b1;
    tWr = cyc;
    wait_irq(400);
    chk(n[15:0], m[15:0]);
    chk(nExt[15:0], 16'd3);
    // software stops the converter before low power, so the comparator goes off
    wr(16'hff6e, 8'h00, 8'hff);
    lowPowerReq = 1'b1;
    repeat (4) @(negedge clk);
    chk({15'h0000, compPwr}, 16'h0000);
    end_of_test();
  end
endmodule : tb_top
